// ### include/lcdes_pkg.sv
// Purpose: Shared constants and types of the link core diagnostic and error status bank.
// Assumes: 32-bit register words at byte addresses, one core clock.
// Notes:   Every offset and field position used by the bank lives here, with the correction, error bit and read word reset values.
package lcdes_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [31:0] ADDR_SLEEP_CTRL   = 32'h4000_0030;
  localparam logic [31:0] ADDR_FINE_CORR    = 32'h4000_0040;
  localparam logic [31:0] ADDR_BASE_CORR    = 32'h4000_0044;
  localparam logic [31:0] ADDR_LANE_CTRL    = 32'h4000_0050;
  localparam logic [31:0] ADDR_LANE_READ    = 32'h4000_0054;
  localparam logic [31:0] ADDR_ZONE_UPPER   = 32'h4000_0058;
  localparam logic [31:0] ADDR_ZONE_LOWER   = 32'h4000_005c;
  localparam logic [31:0] ADDR_ERROR_FLAGS  = 32'h4000_0060;
  localparam logic [31:0] ADDR_IRQ_STATUS   = 32'h4000_0068;
  localparam logic [31:0] ADDR_IRQ_MASK     = 32'h4000_006c;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int unsigned FINE_CORR_W       = 10;
  localparam int unsigned BASE_CORR_W       = 27;
  localparam int unsigned SLEEP_APPLY_BIT   = 3;
  localparam int unsigned LANES             = 4;
  localparam int unsigned LANE_W            = 8;
  localparam int unsigned LANE_SEL_W        = 6;
  localparam int unsigned LANE_CTRL_STRIDE  = 8;
  localparam int unsigned LANE_EN_POS       = 7;
  localparam int unsigned ZONE_W            = 16;
  localparam int unsigned REG_ZONE_POS      = 16;
  localparam int unsigned MEM_ZONE_POS      = 0;
  localparam int unsigned ERR_LSB           = 9;
  localparam int unsigned ERR_W             = 9;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] RESET_WORD        = 32'h0000_0000;
  localparam logic [FINE_CORR_W-1:0] FINE_CORR_RST = 10'h000;
  localparam logic [BASE_CORR_W-1:0] BASE_CORR_RST = 27'h000_0000;
  localparam logic [ERR_W-1:0]       ERR_RST       = 9'h000;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // Field order gives bit 17 down to bit 9 of the error flag word.
  typedef struct packed {
    logic overlapping_event_irq_fault;
    logic rx_buffer_null_fault;
    logic tx_buffer_null_fault;
    logic rx_descriptor_null_fault;
    logic tx_descriptor_null_fault;
    logic control_format_fault;
    logic channel_map_fault;
    logic advert_interval_short;
    logic interframe_space_short;
  } lcdes_errors_t;

  typedef struct packed {
    logic                  enable;
    logic [LANE_SEL_W-1:0] select;
  } lcdes_lane_ctrl_t;

  typedef struct packed {
    logic [ZONE_W-1:0] upper;
    logic [ZONE_W-1:0] lower;
  } lcdes_zone_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } lcdes_bus_req_t;

endpackage : lcdes_pkg

// ### hw/lcdes_bank.sv
// Purpose: Register bank of the link core: timebase corrections, diagnostic lanes,
//          debug address zones and link error status with an interrupt.
// Assumes: All inputs come from logic on core_clk_i; no pin is sampled here.
// Notes:   Read data stand in the cycle after the read strobe and only there.
//
// Summary of operation
// - 10-bit fine phase correction, read/write, resets zero.
// - 27-bit base time correction, read/write, resets zero.
// - Apply bit loads corrections after wake, self-clears.
// - Disabled lane drives all zeros.
// - Six-bit select chooses lane source when enabled.
// - Readback shows four live lane bytes, lane0 low.
// - Register zone limits in upper register halves.
// - Memory zone limits in lower register halves.
// - Bit 17 flags unacknowledged overlapping event interrupts.
// - Bit 16 flags null receive buffer pointer.
// - Bit 15 flags null transmit buffer pointer.
// - Bit 14 flags null receive descriptor pointer.
// - Bit 13 flags null transmit descriptor pointer.
// - Bit 12 flags invalid control format.
// - Bit 11 flags channel map count mismatch.
// - Bit 10 flags advertising interval too short.
// - Bit 9 flags inter-frame space too short.
//
// Implementation choice: the plain strobed port.
module lcdes_bank #(
  parameter int unsigned NUM_SOURCES = 64
) (
  input  wire logic                                       core_clk_i,
  input  wire logic                                       sys_rst_i,
  // Register port.
  input  wire logic [31:0]                                reg_addr_i,
  input  wire logic [31:0]                                reg_wdata_i,
  input  wire logic                                       reg_wr_i,
  input  wire logic                                       reg_rd_i,
  output logic      [31:0]                                reg_rdata_o,
  // Timebase correction towards the fine and base time counters.
  input  wire logic                                       sleep_active_i,
  output logic                                            corr_load_o,
  output logic      [lcdes_pkg::FINE_CORR_W-1:0]          fine_corr_o,
  output logic      [lcdes_pkg::BASE_CORR_W-1:0]          base_corr_o,
  // Diagnostic lanes.
  input  wire logic [NUM_SOURCES-1:0][lcdes_pkg::LANE_W-1:0] diag_source_i,
  output logic      [lcdes_pkg::LANES-1:0][lcdes_pkg::LANE_W-1:0] lane_output_o,
  // Debug address zones.
  input  wire logic [lcdes_pkg::ZONE_W-1:0]               reg_access_addr_i,
  input  wire logic [lcdes_pkg::ZONE_W-1:0]               mem_access_addr_i,
  output logic                                            register_zone_hit_o,
  output logic                                            memory_zone_hit_o,
  // Link error conditions and interrupt.
  input  wire lcdes_pkg::lcdes_errors_t                   link_errors_i,
  output logic                                            irq_o
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The select field can name at most 64 sources.
  if (NUM_SOURCES < 1 || NUM_SOURCES > (1 << lcdes_pkg::LANE_SEL_W)) begin : g_chk
    $error("NUM_SOURCES must lie between 1 and 64");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic in_zone(input lcdes_pkg::lcdes_zone_t z,
                                   input logic [lcdes_pkg::ZONE_W-1:0] a);
    in_zone = (a >= z.lower) && (a <= z.upper);
  endfunction

  function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
    hit = (a == b);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic [lcdes_pkg::FINE_CORR_W-1:0]                 fine_q, fine_d;
  logic [lcdes_pkg::BASE_CORR_W-1:0]                 base_q, base_d;
  logic                                              apply_q, apply_d;
  logic                                              load_q, load_d;
  lcdes_pkg::lcdes_lane_ctrl_t [lcdes_pkg::LANES-1:0] lane_ctrl_q, lane_ctrl_d;
  logic [lcdes_pkg::LANES-1:0][lcdes_pkg::LANE_W-1:0] lane_q, lane_d;
  lcdes_pkg::lcdes_zone_t                            reg_zone_q, reg_zone_d;
  lcdes_pkg::lcdes_zone_t                            mem_zone_q, mem_zone_d;
  logic                                              reg_hit_q, reg_hit_d;
  logic                                              mem_hit_q, mem_hit_d;
  logic [lcdes_pkg::ERR_W-1:0]                       err_q, err_d;
  logic [lcdes_pkg::ERR_W-1:0]                       irq_stat_q, irq_stat_d;
  logic [lcdes_pkg::ERR_W-1:0]                       irq_mask_q, irq_mask_d;
  logic [31:0]                                       rdata_q, rdata_d;
  lcdes_pkg::lcdes_bus_req_t                         req;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // ****************************************************************
  // Timebase corrections
  // ****************************************************************
  always_comb begin
    fine_d  = fine_q;
    base_d  = base_q;
    apply_d = apply_q;
    load_d  = 1'b0;
    if (req.wr && hit(req.addr, lcdes_pkg::ADDR_FINE_CORR)) begin
      fine_d = req.wdata[lcdes_pkg::FINE_CORR_W-1:0];
    end
    if (req.wr && hit(req.addr, lcdes_pkg::ADDR_BASE_CORR)) begin
      base_d = req.wdata[lcdes_pkg::BASE_CORR_W-1:0];
    end
    // The request waits while the core still sleeps, so a write made just
    // before wake is not lost; writing zero never cancels a pending request.
    if (apply_q && !sleep_active_i) begin
      load_d  = 1'b1;
      apply_d = 1'b0;
    end
    if (req.wr && hit(req.addr, lcdes_pkg::ADDR_SLEEP_CTRL)
        && req.wdata[lcdes_pkg::SLEEP_APPLY_BIT]) begin
      apply_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      fine_q  <= lcdes_pkg::FINE_CORR_RST;
      base_q  <= lcdes_pkg::BASE_CORR_RST;
      apply_q <= 1'b0;
      load_q  <= 1'b0;
    end else begin
      fine_q  <= fine_d;
      base_q  <= base_d;
      apply_q <= apply_d;
      load_q  <= load_d;
    end
  end

  assign corr_load_o = load_q;
  assign fine_corr_o = fine_q;
  assign base_corr_o = base_q;

  // ****************************************************************
  // Diagnostic lanes
  // ****************************************************************
  always_comb begin
    lane_ctrl_d = lane_ctrl_q;
    lane_d      = '0;
    if (req.wr && hit(req.addr, lcdes_pkg::ADDR_LANE_CTRL)) begin
      for (int i = 0; i < lcdes_pkg::LANES; i++) begin
        lane_ctrl_d[i].enable =
          req.wdata[i*lcdes_pkg::LANE_CTRL_STRIDE + lcdes_pkg::LANE_EN_POS];
        lane_ctrl_d[i].select =
          req.wdata[i*lcdes_pkg::LANE_CTRL_STRIDE +: lcdes_pkg::LANE_SEL_W];
      end
    end
    for (int i = 0; i < lcdes_pkg::LANES; i++) begin
      // A select beyond the wired sources shows zero rather than wrapping.
      if (lane_ctrl_q[i].enable && (32'(lane_ctrl_q[i].select) < NUM_SOURCES)) begin
        lane_d[i] = diag_source_i[lane_ctrl_q[i].select];
      end else begin
        lane_d[i] = '0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      lane_ctrl_q <= '0;
      lane_q      <= '0;
    end else begin
      lane_ctrl_q <= lane_ctrl_d;
      lane_q      <= lane_d;
    end
  end

  assign lane_output_o = lane_q;

  // ****************************************************************
  // Debug address zones
  // ****************************************************************
  always_comb begin
    reg_zone_d = reg_zone_q;
    mem_zone_d = mem_zone_q;
    if (req.wr && hit(req.addr, lcdes_pkg::ADDR_ZONE_UPPER)) begin
      reg_zone_d.upper = req.wdata[lcdes_pkg::REG_ZONE_POS +: lcdes_pkg::ZONE_W];
      mem_zone_d.upper = req.wdata[lcdes_pkg::MEM_ZONE_POS +: lcdes_pkg::ZONE_W];
    end
    if (req.wr && hit(req.addr, lcdes_pkg::ADDR_ZONE_LOWER)) begin
      reg_zone_d.lower = req.wdata[lcdes_pkg::REG_ZONE_POS +: lcdes_pkg::ZONE_W];
      mem_zone_d.lower = req.wdata[lcdes_pkg::MEM_ZONE_POS +: lcdes_pkg::ZONE_W];
    end
    reg_hit_d = in_zone(reg_zone_q, reg_access_addr_i);
    mem_hit_d = in_zone(mem_zone_q, mem_access_addr_i);
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reg_zone_q <= '0;
      mem_zone_q <= '0;
      reg_hit_q  <= 1'b0;
      mem_hit_q  <= 1'b0;
    end else begin
      reg_zone_q <= reg_zone_d;
      mem_zone_q <= mem_zone_d;
      reg_hit_q  <= reg_hit_d;
      mem_hit_q  <= mem_hit_d;
    end
  end

  assign register_zone_hit_o = reg_hit_q;
  assign memory_zone_hit_o   = mem_hit_q;

  // ****************************************************************
  // Link errors and interrupt
  // ****************************************************************
  always_comb begin
    // Flags follow the error conditions; software writes never reach them.
    err_d      = link_errors_i;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    if (req.wr && hit(req.addr, lcdes_pkg::ADDR_IRQ_STATUS)) begin
      irq_stat_d = irq_stat_q & ~req.wdata[lcdes_pkg::ERR_LSB +: lcdes_pkg::ERR_W];
    end
    if (req.wr && hit(req.addr, lcdes_pkg::ADDR_IRQ_MASK)) begin
      irq_mask_d = req.wdata[lcdes_pkg::ERR_LSB +: lcdes_pkg::ERR_W];
    end
    // A new error that lands on a clear still sets the bit: set wins.
    irq_stat_d = irq_stat_d | (link_errors_i & ~err_q);
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      err_q      <= lcdes_pkg::ERR_RST;
      irq_stat_q <= lcdes_pkg::ERR_RST;
      irq_mask_q <= lcdes_pkg::ERR_RST;
    end else begin
      err_q      <= err_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rdata_d = lcdes_pkg::RESET_WORD;
    if (req.rd) begin
      case (req.addr)
        lcdes_pkg::ADDR_SLEEP_CTRL: begin
          rdata_d[lcdes_pkg::SLEEP_APPLY_BIT] = apply_q;
        end
        lcdes_pkg::ADDR_FINE_CORR: begin
          rdata_d[lcdes_pkg::FINE_CORR_W-1:0] = fine_q;
        end
        lcdes_pkg::ADDR_BASE_CORR: begin
          rdata_d[lcdes_pkg::BASE_CORR_W-1:0] = base_q;
        end
        lcdes_pkg::ADDR_LANE_CTRL: begin
          for (int i = 0; i < lcdes_pkg::LANES; i++) begin
            rdata_d[i*lcdes_pkg::LANE_CTRL_STRIDE + lcdes_pkg::LANE_EN_POS] =
              lane_ctrl_q[i].enable;
            rdata_d[i*lcdes_pkg::LANE_CTRL_STRIDE +: lcdes_pkg::LANE_SEL_W] =
              lane_ctrl_q[i].select;
          end
        end
        lcdes_pkg::ADDR_LANE_READ: begin
          rdata_d = lane_q;
        end
        lcdes_pkg::ADDR_ZONE_UPPER: begin
          rdata_d = {reg_zone_q.upper, mem_zone_q.upper};
        end
        lcdes_pkg::ADDR_ZONE_LOWER: begin
          rdata_d = {reg_zone_q.lower, mem_zone_q.lower};
        end
        lcdes_pkg::ADDR_ERROR_FLAGS: begin
          rdata_d[lcdes_pkg::ERR_LSB +: lcdes_pkg::ERR_W] = err_q;
        end
        lcdes_pkg::ADDR_IRQ_STATUS: begin
          rdata_d[lcdes_pkg::ERR_LSB +: lcdes_pkg::ERR_W] = irq_stat_q;
        end
        lcdes_pkg::ADDR_IRQ_MASK: begin
          rdata_d[lcdes_pkg::ERR_LSB +: lcdes_pkg::ERR_W] = irq_mask_q;
        end
        default: begin
          rdata_d = lcdes_pkg::RESET_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= lcdes_pkg::RESET_WORD;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule // lcdes_bank

// ### sim/lcdes_bank_monitor.sv
// Purpose: Concurrent checks on the ports of the link core register bank.
// Assumes: One core clock, synchronous active-high reset.
// Notes:   Sees only top-level ports, so lane and zone internals are judged by the bench.
module lcdes_bank_monitor #(
  parameter int unsigned NUM_SOURCES = 64
) (
  input wire logic                           core_clk_i,
  input wire logic                           sys_rst_i,
  input wire logic [31:0]                    reg_addr_i,
  input wire logic [31:0]                    reg_wdata_i,
  input wire logic                           reg_wr_i,
  input wire logic                           reg_rd_i,
  input wire logic [31:0]                    reg_rdata_o,
  input wire logic                           sleep_active_i,
  input wire logic                           corr_load_o,
  input wire logic [9:0]                     fine_corr_o,
  input wire logic [26:0]                    base_corr_o,
  input wire logic [3:0][7:0]                lane_output_o,
  input wire lcdes_pkg::lcdes_errors_t       link_errors_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_FINE_WRITE: assert property (reg_wr_i && reg_addr_i == lcdes_pkg::ADDR_FINE_CORR
    |=> fine_corr_o == $past(reg_wdata_i[9:0])) else $error("fine correction not written");
  AST_FINE_HOLD: assert property (!(reg_wr_i && reg_addr_i == lcdes_pkg::ADDR_FINE_CORR)
    |=> $stable(fine_corr_o)) else $error("fine correction changed without write");
  AST_FINE_READ: assert property (reg_rd_i && reg_addr_i == lcdes_pkg::ADDR_FINE_CORR
    |=> reg_rdata_o == {22'h0, fine_corr_o}) else $error("fine correction read wrong");
  AST_BASE_WRITE: assert property (reg_wr_i && reg_addr_i == lcdes_pkg::ADDR_BASE_CORR
    |=> base_corr_o == $past(reg_wdata_i[26:0])) else $error("base correction not written");
  AST_LOAD_PULSE: assert property (corr_load_o |=> !corr_load_o)
    else $error("load pulse too long");
  AST_LOAD_AWAKE: assert property (corr_load_o |-> !$past(sleep_active_i))
    else $error("load while asleep");
  AST_LOAD_SOON: assert property (reg_wr_i && reg_addr_i == lcdes_pkg::ADDR_SLEEP_CTRL
    && reg_wdata_i[3] ##1 !sleep_active_i |=> corr_load_o) else $error("load missing");
  AST_LANE_READ: assert property (reg_rd_i && reg_addr_i == lcdes_pkg::ADDR_LANE_READ
    |=> reg_rdata_o == $past(lane_output_o)) else $error("lane readback wrong");
  AST_ERR_READ: assert property (reg_rd_i && reg_addr_i == lcdes_pkg::ADDR_ERROR_FLAGS
    |=> reg_rdata_o == {14'h0, $past(link_errors_i, 2), 9'h0}) else $error("error flags wrong");
endmodule // lcdes_bank_monitor

bind lcdes_bank lcdes_bank_monitor #(.NUM_SOURCES(NUM_SOURCES)) u_monitor (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .sleep_active_i(sleep_active_i), .corr_load_o(corr_load_o),
  .fine_corr_o(fine_corr_o), .base_corr_o(base_corr_o), .lane_output_o(lane_output_o),
  .link_errors_i(link_errors_i));

// ### sim/tb.sv
// Purpose: Self-checking bench of the link core register bank.
// Assumes: Default of 64 diagnostic sources.
// Notes:   Stimulus is random from a fixed seed with boundary cases mixed in.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       core_clk_i = 1'b0;
  logic                       sys_rst_i = 1'b1;
  logic [31:0]                addr = 32'h0, wdata = 32'h0, rdata, v, c, e32;
  logic                       wr_s = 1'b0, rd_s = 1'b0, sleep = 1'b0;
  logic                       corr_load, rhit, mhit, irq;
  logic [9:0]                 fine;
  logic [26:0]                base;
  logic [63:0][7:0]           src = '0, srcv;
  logic [3:0][7:0]            lanes;
  logic [15:0]                racc = 16'h0, macc = 16'h0, rl, ru, ml, mu;
  logic [8:0]                 e;
  lcdes_pkg::lcdes_errors_t   errs = '0;
  int                         err_count = 0, n_tests = 0, cycles = 0, loads = 0;

  lcdes_bank uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .sleep_active_i(sleep), .corr_load_o(corr_load), .fine_corr_o(fine), .base_corr_o(base),
    .diag_source_i(src), .lane_output_o(lanes), .reg_access_addr_i(racc),
    .mem_access_addr_i(macc), .register_zone_hit_o(rhit), .memory_zone_hit_o(mhit),
    .link_errors_i(errs), .irq_o(irq));

  always #10 core_clk_i = ~core_clk_i;
  // A hung handshake would otherwise stall the run forever.
  always @(posedge core_clk_i) begin
    cycles++;
    if (corr_load) loads++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr <= a; wdata <= d; wr_s <= 1'b1;
    @(posedge core_clk_i);
    wr_s <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    addr <= a; rd_s <= 1'b1;
    @(posedge core_clk_i);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [7:0] lane_exp(input logic [31:0] k, input int i);
    return k[8*i+7] ? src[k[8*i +: 6]] : 8'h00;
  endfunction
  function automatic logic inz(input logic [15:0] a, l, u);
    return a >= l && a <= u;
  endfunction

  initial begin
    void'($urandom(32'hd887d39d));
    repeat (12) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(32'h4000_0040 + 4 * i, v);
      check(v, 32'h0);
    end
    $display("test reset done");
    repeat (4) begin
      c = $urandom;
      wr(lcdes_pkg::ADDR_FINE_CORR, c);
      wr(lcdes_pkg::ADDR_BASE_CORR, ~c);
      rd(lcdes_pkg::ADDR_FINE_CORR, v);
      check(v, {22'h0, c[9:0]});
      rd(lcdes_pkg::ADDR_BASE_CORR, v);
      check(v, {5'h0, ~c[26:0]});
      check({5'h0, base}, {5'h0, ~c[26:0]});
      check({22'h0, fine}, {22'h0, c[9:0]});
    end
    @(posedge core_clk_i);
    sleep <= 1'b1;
    wr(lcdes_pkg::ADDR_SLEEP_CTRL, 32'h8);
    wr(lcdes_pkg::ADDR_SLEEP_CTRL, 32'h8);
    repeat (5) @(posedge core_clk_i);
    check(loads, 0);
    sleep <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    wr(lcdes_pkg::ADDR_SLEEP_CTRL, 32'h0);
    repeat (5) @(posedge core_clk_i);
    #1 check(loads, 1);
    // A request made while awake must load on its own, with no sleep exit.
    wr(lcdes_pkg::ADDR_SLEEP_CTRL, 32'h8);
    repeat (3) @(posedge core_clk_i);
    #1 check(loads, 2);
    $display("test correction done");
    for (int i = 0; i < 64; i++) srcv[i] = 8'($urandom);
    @(posedge core_clk_i);
    src <= srcv;
    for (int t = 0; t < 8; t++) begin
      c = (t == 0) ? 32'hbfbf_bfbf : (t == 1) ? 32'h3f3f_3f3f : $urandom & 32'hbfbf_bfbf;
      wr(lcdes_pkg::ADDR_LANE_CTRL, c);
      wr(lcdes_pkg::ADDR_LANE_READ, 32'hffff_ffff);
      e32 = {lane_exp(c, 3), lane_exp(c, 2), lane_exp(c, 1), lane_exp(c, 0)};
      check(lanes, e32);
      rd(lcdes_pkg::ADDR_LANE_READ, v);
      check(v, e32);
      rd(lcdes_pkg::ADDR_LANE_CTRL, v);
      check(v, c);
    end
    $display("test lanes done");
    repeat (3) begin
      rl = 16'($urandom % 16'h8000 + 1); ru = rl + 16'($urandom % 16'h100);
      ml = 16'($urandom % 16'h8000 + 1); mu = ml + 16'($urandom % 16'h100);
      wr(lcdes_pkg::ADDR_ZONE_UPPER, {ru, mu});
      wr(lcdes_pkg::ADDR_ZONE_LOWER, {rl, ml});
      rd(lcdes_pkg::ADDR_ZONE_UPPER, v);
      check(v, {ru, mu});
      rd(lcdes_pkg::ADDR_ZONE_LOWER, v);
      check(v, {rl, ml});
      for (int k = 0; k < 4; k++) begin
        @(posedge core_clk_i);
        racc <= (k < 2) ? rl - 16'(1 - k) : ru + 16'(k - 2);
        macc <= (k < 2) ? ml - 16'(1 - k) : mu + 16'(k - 2);
        repeat (2) @(posedge core_clk_i);
        #1 check({30'h0, rhit, mhit}, {30'h0, inz(racc, rl, ru), inz(macc, ml, mu)});
      end
    end
    $display("test zones done");
    for (int b = 0; b < 9; b++) begin
      e = 9'h1 << b;
      e32 = {14'h0, e, 9'h0};
      @(posedge core_clk_i);
      errs <= lcdes_pkg::lcdes_errors_t'(e);
      repeat (3) @(posedge core_clk_i);
      rd(lcdes_pkg::ADDR_ERROR_FLAGS, v);
      check(v, e32);
      check({31'h0, irq}, 32'h0);
      wr(lcdes_pkg::ADDR_IRQ_MASK, e32);
      check({31'h0, irq}, 32'h1);
      @(posedge core_clk_i);
      errs <= '0;
      wr(lcdes_pkg::ADDR_ERROR_FLAGS, 32'hffff_ffff);
      rd(lcdes_pkg::ADDR_IRQ_STATUS, v);
      check(v, e32);
      wr(lcdes_pkg::ADDR_IRQ_STATUS, e32);
      rd(lcdes_pkg::ADDR_ERROR_FLAGS, v);
      check(v, 32'h0);
      check({31'h0, irq}, 32'h0);
      wr(lcdes_pkg::ADDR_IRQ_MASK, 32'h0);
    end
    $display("test errors done");
    results();
  end
endmodule // tb
